// ### dv/host_model.sv
// host-side model that drives the register port one byte at a time
`timescale 1ns/100ps
module host_model
(
    input wire logic clk_sys,
    input wire logic [7:0] regRdata,
    output logic [6:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata
);
    // --------------------------------------------------------
    // idle bus
    // --------------------------------------------------------
    initial
    begin
        regAddr = 7'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
    end

    // only addresses on the register map are ever touched
    function automatic logic listed(input logic [6:0] a);
        return !(a <= 7'h0A || a == 7'h0E || a == 7'h13 || (a >= 7'h1B && a <= 7'h24)
            || (a >= 7'h2D && a <= 7'h32) || a > 7'h33);
    endfunction : listed

    // one byte write; the strobe spans exactly one rising edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a <= 7'h0A || (a >= 7'h1B && a <= 7'h24) || (a >= 7'h2D && a <= 7'h32))
            return;
        if (!listed(a))
            return;
        @(negedge clk_sys);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk_sys);
        regWrite = 1'b0;
        regAddr = ~a; // released lines show the inverse, not the old value
        regWdata = ~d;
    endtask : wr

    // one byte read; data is registered and settled by the next falling edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        d = 8'h00;
        if (!listed(a))
            return;
        @(negedge clk_sys);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk_sys);
        regRead = 1'b0;
        regAddr = ~a;
        d = regRdata;
    endtask : rd
endmodule : host_model

// ### dv/pressure_reference_threshold_regs_test.sv
// self-checking bench for the pressure reference and threshold register bank
`timescale 1ns/100ps
module pressure_reference_threshold_regs_test
    import press_pkg::*;
;
    localparam logic [7:0] ID_VAL = 8'hA7; // arbitrary identity value
    localparam logic [7:0] TRIM_VAL = 8'h96;
    localparam logic [6:0] RW_ADDR [13] = '{ADDR_IRQ_CFG, ADDR_THS_LOW, ADDR_THS_HIGH,
        ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_CTRL_THREE, ADDR_QUEUE_CFG, ADDR_REF_XLOW,
        ADDR_REF_LOW, ADDR_REF_HIGH, ADDR_OFS_LOW, ADDR_OFS_HIGH, ADDR_RES_CFG};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [6:0] regAddr;
    logic regWrite;
    logic regRead;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic convDone = 1'b0;
    logic [PRESS_W-1:0] measPressure = '0;
    logic [TEMP_W-1:0] measTemp = '0;
    logic thresholdIrq;
    logic [7:0] calibTrim;
    logic bootDone;
    int failures = 0;
    int checks = 0;

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    pressure_reference_threshold_regs #(.ID_CODE(ID_VAL), .CALIB_TRIM(TRIM_VAL)) dut (
        .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .convDone(convDone), .measPressure(measPressure), .measTemp(measTemp),
        .thresholdIrq(thresholdIrq), .calibTrim(calibTrim), .bootDone(bootDone));

    host_model host (.clk_sys(clk_sys), .regRdata(regRdata), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] got);
        checks++;
        if (got !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask : chk

    task automatic expect_reg(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("register %h", a), {16'h0000, e}, {16'h0000, d});
    endtask : expect_reg

    // reads the three result bytes, low byte first
    task automatic expect_press(input logic [23:0] e);
        logic [7:0] x;
        logic [7:0] l;
        logic [7:0] h;
        host.rd(ADDR_PRESS_XLOW, x);
        host.rd(ADDR_PRESS_LOW, l);
        host.rd(ADDR_PRESS_HIGH, h);
        chk("pressure result", e, {h, l, x});
    endtask : expect_press

    // one conversion pulse; inputs go stale afterwards
    task automatic conv(input logic [23:0] p);
        @(negedge clk_sys);
        convDone = 1'b1;
        measPressure = p;
        measTemp = 16'h1234;
        @(negedge clk_sys);
        convDone = 1'b0;
        measPressure = ~p;
        measTemp = 16'hEDCB;
    endtask : conv

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_map;
        chk("boot done", 24'h000001, {23'h0, bootDone});
        chk("calibration", {16'h0000, TRIM_VAL}, {16'h0000, calibTrim});
        for (int i = 0; i < 13; i++)
            expect_reg(RW_ADDR[i], RW_ADDR[i] == ADDR_CTRL_TWO ? RST_CTRL_TWO : RST_ZERO);
        for (int i = 1; i < 13; i++)
        begin
            host.wr(RW_ADDR[i], 8'h68);
            expect_reg(RW_ADDR[i], 8'h68);
            host.wr(RW_ADDR[i], RW_ADDR[i] == ADDR_CTRL_TWO ? RST_CTRL_TWO : RST_ZERO);
        end
        host.wr(ADDR_IDENTITY, 8'hFF);
        expect_reg(ADDR_IDENTITY, ID_VAL);
        host.wr(ADDR_QUEUE_STATE, 8'hFF);
        expect_reg(ADDR_QUEUE_STATE, 8'h00);
        host.wr(ADDR_FILTER_RES, 8'hFF);
        expect_reg(ADDR_FILTER_RES, 8'h00);
        host.wr(ADDR_SAMPLE_STATE, 8'hFF);
        expect_reg(ADDR_SAMPLE_STATE, 8'h00);
    endtask : t_map

    task automatic t_autozero;
        conv(24'h123456);
        expect_reg(ADDR_SAMPLE_STATE, 8'h03);
        expect_press(24'h123456);
        expect_reg(ADDR_TEMP_LOW, 8'h34);
        expect_reg(ADDR_TEMP_HIGH, 8'h12);
        expect_reg(ADDR_SAMPLE_STATE, 8'h00);
        host.wr(ADDR_IRQ_CFG, 8'h20);
        host.wr(ADDR_PRESS_LOW, 8'hFF);
        conv(24'h123456);
        expect_reg(ADDR_REF_XLOW, 8'h56);
        expect_reg(ADDR_REF_LOW, 8'h34);
        expect_reg(ADDR_REF_HIGH, 8'h12);
        expect_reg(ADDR_IRQ_CFG, 8'h00);
        expect_press(24'h000000);
        conv(24'h123470);
        expect_press(24'h00001A);
        host.wr(ADDR_IRQ_CFG, 8'h10);
        expect_reg(ADDR_IRQ_CFG, 8'h00);
        expect_reg(ADDR_REF_LOW, 8'h00);
        expect_reg(ADDR_REF_HIGH, 8'h00);
        conv(24'h123470);
        expect_press(24'h123470);
    endtask : t_autozero

    task automatic t_offset;
        host.wr(ADDR_OFS_LOW, 8'h02);
        host.wr(ADDR_OFS_HIGH, 8'h00);
        host.wr(ADDR_IRQ_CFG, 8'h80);
        conv(24'h200000);
        expect_press(24'h1FFE00);
        expect_reg(ADDR_REF_HIGH, 8'h20);
        expect_reg(ADDR_IRQ_CFG, 8'h00);
        conv(24'h300000);
        expect_press(24'h2FFE00);
        host.wr(ADDR_IRQ_CFG, 8'h40);
        conv(24'h300000);
        expect_press(24'h300000);
    endtask : t_offset

    // threshold 1 means 256 pressure counts; reference captured at 0x400000
    task automatic t_threshold;
        host.wr(ADDR_THS_LOW, 8'h01);
        host.wr(ADDR_THS_HIGH, 8'h00);
        host.wr(ADDR_IRQ_CFG, 8'h23);
        conv(24'h400000);
        conv(24'h400400);
        chk("irq line", 24'h0, {23'h0, thresholdIrq});
        expect_reg(ADDR_IRQ_SRC, 8'h00);
        host.wr(ADDR_IRQ_CFG, 8'h0B);
        conv(24'h400101);
        chk("irq line", 24'h1, {23'h0, thresholdIrq});
        expect_reg(ADDR_IRQ_SRC, 8'h05);
        conv(24'h400100);
        chk("irq line", 24'h0, {23'h0, thresholdIrq});
        conv(24'h3FFEFF);
        expect_reg(ADDR_IRQ_SRC, 8'h06);
        host.wr(ADDR_IRQ_CFG, 8'h09);
        conv(24'h3FFEFF);
        expect_reg(ADDR_IRQ_SRC, 8'h00);
        host.wr(ADDR_IRQ_CFG, 8'h0F);
        conv(24'h400101);
        conv(24'h400000);
        chk("irq line", 24'h1, {23'h0, thresholdIrq});
        expect_reg(ADDR_IRQ_SRC, 8'h05);
        expect_reg(ADDR_IRQ_SRC, 8'h00);
        chk("irq line", 24'h0, {23'h0, thresholdIrq});
    endtask : t_threshold

    // --------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        t_map();
        t_autozero();
        t_offset();
        t_threshold();
        tally_and_finish();
    end

    // all scenarios need well under 1000 cycles
    initial
    begin
        #100000;
        failures++;
        tally_and_finish();
    end
endmodule : pressure_reference_threshold_regs_test

// ### inc/conv_if.sv
// carrier between the register bank and its threshold comparator
`timescale 1ns/100ps
interface conv_if;
    logic [23:0] diff;
    logic [23:0] limit;
    logic high;
    logic low;
    modport cmp (input diff, input limit, output high, output low);
    modport top (output diff, output limit, input high, input low);
endinterface : conv_if

// ### inc/press_pkg.sv
// constants, field positions and encodings of the pressure register bank
package press_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_IRQ_CFG = 7'h0B;
    localparam logic [6:0] ADDR_THS_LOW = 7'h0C;
    localparam logic [6:0] ADDR_THS_HIGH = 7'h0D;
    localparam logic [6:0] ADDR_IDENTITY = 7'h0F;
    localparam logic [6:0] ADDR_CTRL_ONE = 7'h10;
    localparam logic [6:0] ADDR_CTRL_TWO = 7'h11;
    localparam logic [6:0] ADDR_CTRL_THREE = 7'h12;
    localparam logic [6:0] ADDR_QUEUE_CFG = 7'h14;
    localparam logic [6:0] ADDR_REF_XLOW = 7'h15;
    localparam logic [6:0] ADDR_REF_LOW = 7'h16;
    localparam logic [6:0] ADDR_REF_HIGH = 7'h17;
    localparam logic [6:0] ADDR_OFS_LOW = 7'h18;
    localparam logic [6:0] ADDR_OFS_HIGH = 7'h19;
    localparam logic [6:0] ADDR_RES_CFG = 7'h1A;
    localparam logic [6:0] ADDR_IRQ_SRC = 7'h25;
    localparam logic [6:0] ADDR_QUEUE_STATE = 7'h26;
    localparam logic [6:0] ADDR_SAMPLE_STATE = 7'h27;
    localparam logic [6:0] ADDR_PRESS_XLOW = 7'h28;
    localparam logic [6:0] ADDR_PRESS_LOW = 7'h29;
    localparam logic [6:0] ADDR_PRESS_HIGH = 7'h2A;
    localparam logic [6:0] ADDR_TEMP_LOW = 7'h2B;
    localparam logic [6:0] ADDR_TEMP_HIGH = 7'h2C;
    localparam logic [6:0] ADDR_FILTER_RES = 7'h33;
    // ------------------------------------------------------------
    // interrupt_config fields
    // ------------------------------------------------------------
    localparam int BIT_OFFSET_MODE = 7;
    localparam int BIT_OFFSET_CLEAR = 6;
    localparam int BIT_AUTOZERO = 5;
    localparam int BIT_ZERO_CLEAR = 4;
    localparam int BIT_THR_EN = 3;
    localparam int BIT_LATCH = 2;
    localparam int BIT_LOW_EN = 1;
    localparam int BIT_HIGH_EN = 0;
    // ------------------------------------------------------------
    // irq_source and sample_state fields
    // ------------------------------------------------------------
    localparam int SRC_ACTIVE = 2;
    localparam int SRC_LOW = 1;
    localparam int SRC_HIGH = 0;
    localparam int STAT_PRESS = 0;
    localparam int STAT_TEMP = 1;
    // ------------------------------------------------------------
    // reset values, widths and scaling
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h10;
    localparam int PRESS_W = 24;
    localparam int TEMP_W = 16;
    localparam logic [7:0] SCALE_PAD = 8'h00; // times 256 for offset and threshold
    typedef enum logic [1:0] {
        BOOT_IDLE = 2'b00,
        BOOT_LOAD = 2'b01,
        BOOT_DONE = 2'b10
    } boot_t;
endpackage : press_pkg

// ### verilog/pressure_reference_threshold_regs.sv
// register bank with pressure reference and threshold interrupt logic
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module pressure_reference_threshold_regs
    import press_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A, // arbitrary identity value
    parameter logic [7:0] CALIB_TRIM = 8'h3C // calibration word reloaded at boot
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [6:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic convDone,
    input wire logic [PRESS_W-1:0] measPressure,
    input wire logic [TEMP_W-1:0] measTemp,
    output logic thresholdIrq,
    output logic [7:0] calibTrim,
    output logic bootDone
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] thsLow;
        logic [7:0] thsHigh;
        logic [7:0] ctrlOne;
        logic [7:0] ctrlTwo;
        logic [7:0] ctrlThree;
        logic [7:0] queueCfg;
        logic [PRESS_W-1:0] refP;
        logic [15:0] offset;
        logic [7:0] resCfg;
        logic [7:0] src;
        logic statP;
        logic statT;
        logic [PRESS_W-1:0] pressOut;
        logic [TEMP_W-1:0] tempOut;
        logic zeroMode;
        logic offsetMode;
        logic [7:0] calib;
        boot_t boot;
        logic [7:0] rdata;
    } state_t;

    state_t st;
    state_t next_st;
    conv_if cf ();
    logic capZero;
    logic capOffset;
    logic modeActive;
    logic [PRESS_W-1:0] refNow;
    logic evHigh;
    logic evLow;

    // ------------------------------------------------------------
    // comparator hookup
    // ------------------------------------------------------------
    // a capture in this conversion makes the fresh sample the reference
    assign capZero = convDone && st.cfg[BIT_AUTOZERO];
    assign capOffset = convDone && st.cfg[BIT_OFFSET_MODE];
    assign refNow = (capZero || capOffset) ? measPressure : st.refP;
    assign modeActive = st.zeroMode || st.offsetMode || capZero || capOffset;
    assign cf.diff = measPressure - refNow;
    assign cf.limit = {st.thsHigh, st.thsLow, SCALE_PAD};
    assign evHigh = st.cfg[BIT_THR_EN] && modeActive && st.cfg[BIT_HIGH_EN] && cf.high;
    assign evLow = st.cfg[BIT_THR_EN] && modeActive && st.cfg[BIT_LOW_EN] && cf.low;

    threshold_compare u_cmp (
        .cf (cf)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // boot sequence reloads calibration once after reset
        case (st.boot)
            BOOT_IDLE: next_st.boot = BOOT_LOAD;
            BOOT_LOAD:
            begin
                next_st.calib = CALIB_TRIM;
                next_st.boot = BOOT_DONE;
            end
            BOOT_DONE: next_st.boot = BOOT_DONE;
            default: next_st.boot = BOOT_IDLE;
        endcase
        // read answer and read side effects
        if (regRead)
        begin
            case (regAddr)
                ADDR_IRQ_CFG: next_st.rdata = st.cfg;
                ADDR_THS_LOW: next_st.rdata = st.thsLow;
                ADDR_THS_HIGH: next_st.rdata = st.thsHigh;
                ADDR_IDENTITY: next_st.rdata = ID_CODE;
                ADDR_CTRL_ONE: next_st.rdata = st.ctrlOne;
                ADDR_CTRL_TWO: next_st.rdata = st.ctrlTwo;
                ADDR_CTRL_THREE: next_st.rdata = st.ctrlThree;
                ADDR_QUEUE_CFG: next_st.rdata = st.queueCfg;
                ADDR_REF_XLOW: next_st.rdata = st.refP[7:0];
                ADDR_REF_LOW: next_st.rdata = st.refP[15:8];
                ADDR_REF_HIGH: next_st.rdata = st.refP[23:16];
                ADDR_OFS_LOW: next_st.rdata = st.offset[7:0];
                ADDR_OFS_HIGH: next_st.rdata = st.offset[15:8];
                ADDR_RES_CFG: next_st.rdata = st.resCfg;
                ADDR_IRQ_SRC: next_st.rdata = st.src;
                ADDR_SAMPLE_STATE: next_st.rdata = {6'h00, st.statT, st.statP};
                ADDR_PRESS_XLOW: next_st.rdata = st.pressOut[7:0];
                ADDR_PRESS_LOW: next_st.rdata = st.pressOut[15:8];
                ADDR_PRESS_HIGH: next_st.rdata = st.pressOut[23:16];
                ADDR_TEMP_LOW: next_st.rdata = st.tempOut[7:0];
                ADDR_TEMP_HIGH: next_st.rdata = st.tempOut[15:8];
                default: next_st.rdata = RST_ZERO;
            endcase
            if (regAddr == ADDR_IRQ_SRC && st.cfg[BIT_LATCH])
                next_st.src = RST_ZERO; // reading releases latched events
            if (regAddr == ADDR_PRESS_HIGH)
                next_st.statP = 1'b0;
            if (regAddr == ADDR_TEMP_HIGH)
                next_st.statT = 1'b0;
        end
        // writes; read-only and unmapped addresses fall to default
        if (regWrite)
        begin
            case (regAddr)
                ADDR_IRQ_CFG:
                begin
                    next_st.cfg = regWdata;
                    next_st.cfg[BIT_ZERO_CLEAR] = 1'b0;
                    next_st.cfg[BIT_OFFSET_CLEAR] = 1'b0;
                    if (regWdata[BIT_ZERO_CLEAR])
                    begin
                        next_st.zeroMode = 1'b0;
                        next_st.refP = '0;
                    end
                    if (regWdata[BIT_OFFSET_CLEAR])
                        next_st.offsetMode = 1'b0;
                end
                ADDR_THS_LOW: next_st.thsLow = regWdata;
                ADDR_THS_HIGH: next_st.thsHigh = regWdata;
                ADDR_CTRL_ONE: next_st.ctrlOne = regWdata;
                ADDR_CTRL_TWO: next_st.ctrlTwo = regWdata;
                ADDR_CTRL_THREE: next_st.ctrlThree = regWdata;
                ADDR_QUEUE_CFG: next_st.queueCfg = regWdata;
                ADDR_REF_XLOW: next_st.refP[7:0] = regWdata;
                ADDR_REF_LOW: next_st.refP[15:8] = regWdata;
                ADDR_REF_HIGH: next_st.refP[23:16] = regWdata;
                ADDR_OFS_LOW: next_st.offset[7:0] = regWdata;
                ADDR_OFS_HIGH: next_st.offset[15:8] = regWdata;
                ADDR_RES_CFG: next_st.resCfg = regWdata;
                default: next_st.rdata = next_st.rdata;
            endcase
        end
        // conversion: capture, output update and events; sets win
        if (convDone)
        begin
            if (capZero)
            begin
                next_st.refP = measPressure;
                next_st.zeroMode = 1'b1;
                next_st.cfg[BIT_AUTOZERO] = 1'b0;
            end
            if (capOffset)
            begin
                next_st.refP = measPressure;
                next_st.offsetMode = 1'b1;
                next_st.cfg[BIT_OFFSET_MODE] = 1'b0;
            end
            if (st.zeroMode || capZero)
                next_st.pressOut = measPressure - refNow;
            else if (st.offsetMode || capOffset)
                next_st.pressOut = measPressure - {st.offset, SCALE_PAD};
            else
                next_st.pressOut = measPressure;
            next_st.tempOut = measTemp;
            next_st.statP = 1'b1;
            next_st.statT = 1'b1;
            if (st.cfg[BIT_LATCH])
                next_st.src = next_st.src | {5'h00, evHigh || evLow, evLow, evHigh};
            else
                next_st.src = {5'h00, evHigh || evLow, evLow, evHigh};
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.ctrlTwo <= RST_CTRL_TWO;
            st.boot <= BOOT_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign regRdata = st.rdata;
    assign thresholdIrq = st.src[SRC_ACTIVE];
    assign calibTrim = st.calib;
    assign bootDone = (st.boot == BOOT_DONE);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_reg_write;
        @(posedge clk_sys) disable iff (rst)
        regWrite && regAddr == ADDR_THS_LOW |=> st.thsLow == $past(regWdata);
    endproperty
    a_reg_write: assert property (p_reg_write) else $error("threshold low not stored");

    property p_boot_load;
        @(posedge clk_sys) disable iff (rst)
        $rose(bootDone) |-> calibTrim == CALIB_TRIM && $past(st.boot) == BOOT_LOAD;
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("calibration not reloaded");

    property p_enable_gate;
        @(posedge clk_sys) disable iff (rst)
        convDone && !st.cfg[BIT_THR_EN] && !st.cfg[BIT_LATCH] |=> !thresholdIrq;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("event while disabled");

    property p_no_latch;
        @(posedge clk_sys) disable iff (rst)
        convDone && !st.cfg[BIT_LATCH] && !cf.high && !cf.low |=> st.src == RST_ZERO;
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("unlatched event held");

    property p_low_event;
        @(posedge clk_sys) disable iff (rst)
        convDone && st.cfg[BIT_THR_EN] && st.cfg[BIT_LOW_EN] && modeActive && cf.low
        |=> st.src[SRC_LOW] && thresholdIrq;
    endproperty
    a_low_event: assert property (p_low_event) else $error("low event missed");

    property p_high_event;
        @(posedge clk_sys) disable iff (rst)
        convDone && st.cfg[BIT_THR_EN] && st.cfg[BIT_HIGH_EN] && modeActive && cf.high
        |=> st.src[SRC_HIGH] && thresholdIrq;
    endproperty
    a_high_event: assert property (p_high_event) else $error("high event missed");

    property p_zero_capture;
        @(posedge clk_sys) disable iff (rst)
        capZero |=> st.refP == $past(measPressure) && st.pressOut == '0 && st.zeroMode
            && !st.cfg[BIT_AUTOZERO];
    endproperty
    a_zero_capture: assert property (p_zero_capture) else $error("autozero capture wrong");

    property p_zero_clear;
        @(posedge clk_sys) disable iff (rst)
        regWrite && regAddr == ADDR_IRQ_CFG && regWdata[BIT_ZERO_CLEAR] && !convDone
        |=> !st.zeroMode && st.refP == '0 && !st.cfg[BIT_ZERO_CLEAR];
    endproperty
    a_zero_clear: assert property (p_zero_clear) else $error("zero clear failed");

    property p_offset_out;
        @(posedge clk_sys) disable iff (rst)
        convDone && st.offsetMode && !st.zeroMode && !capZero
        |=> st.pressOut == $past(measPressure) - {$past(st.offset), SCALE_PAD};
    endproperty
    a_offset_out: assert property (p_offset_out) else $error("offset output wrong");

    property p_offset_clear;
        @(posedge clk_sys) disable iff (rst)
        capOffset |=> !st.cfg[BIT_OFFSET_MODE] && st.offsetMode;
    endproperty
    a_offset_clear: assert property (p_offset_clear) else $error("offset bit stuck");

    property p_read_only;
        @(posedge clk_sys) disable iff (rst)
        regWrite && regAddr == ADDR_IRQ_SRC && !convDone && !regRead |=> $stable(st.src);
    endproperty
    a_read_only: assert property (p_read_only) else $error("read-only register written");

    // read answer, status, event bookkeeping and offset clear
    property p_read_answer;
        @(posedge clk_sys) disable iff (rst)
        regRead && regAddr == ADDR_IRQ_CFG |=> regRdata == $past(st.cfg);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("config read wrong");

    property p_status_set;
        @(posedge clk_sys) disable iff (rst)
        convDone |=> st.statP && st.statT;
    endproperty
    a_status_set: assert property (p_status_set) else $error("ready bits not set");

    property p_src_idle;
        @(posedge clk_sys) disable iff (rst)
        !convDone && !(regRead && regAddr == ADDR_IRQ_SRC) |=> $stable(st.src);
    endproperty
    a_src_idle: assert property (p_src_idle) else $error("event bits moved");

    property p_latch_hold;
        @(posedge clk_sys) disable iff (rst)
        st.cfg[BIT_LATCH] && thresholdIrq && !(regRead && regAddr == ADDR_IRQ_SRC)
        |=> thresholdIrq;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched event lost");

    property p_mode_gate;
        @(posedge clk_sys) disable iff (rst)
        convDone && !modeActive && !st.cfg[BIT_LATCH] |=> !thresholdIrq;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("event with no reference mode");

    property p_offset_end;
        @(posedge clk_sys) disable iff (rst)
        regWrite && regAddr == ADDR_IRQ_CFG && regWdata[BIT_OFFSET_CLEAR] && !convDone
        |=> !st.offsetMode && !st.cfg[BIT_OFFSET_CLEAR];
    endproperty
    a_offset_end: assert property (p_offset_end) else $error("offset clear failed");

    // main scenarios reached by the bench
    c_zero_mode: cover property (@(posedge clk_sys) disable iff (rst) capZero ##1 st.zeroMode);
    c_latched: cover property (@(posedge clk_sys) disable iff (rst)
        st.cfg[BIT_LATCH] && thresholdIrq ##1 thresholdIrq);
    c_offset_mode: cover property (@(posedge clk_sys) disable iff (rst) capOffset);
    c_low_irq: cover property (@(posedge clk_sys) disable iff (rst) evLow);
    c_high_irq: cover property (@(posedge clk_sys) disable iff (rst) evHigh);
endmodule : pressure_reference_threshold_regs

// ### verilog/threshold_compare.sv
// signed differential pressure against a symmetric threshold
`timescale 1ns/100ps
module threshold_compare
    import press_pkg::*;
(
    conv_if.cmp cf
);
    logic signed [24:0] dExt;
    logic signed [24:0] lExt;

    // ------------------------------------------------------------
    // compare
    // ------------------------------------------------------------
    // diff is two's complement, limit is unsigned scaled threshold
    always_comb
    begin
        dExt = {cf.diff[23], cf.diff};
        lExt = {1'b0, cf.limit};
        cf.high = dExt > lExt;
        cf.low = dExt < -lExt;
    end
endmodule : threshold_compare
